// File: shared/irq_ctrl_defs.vh
// Constants for the prioritized interrupt controller.
// Assumes an 8-bit special register bus with byte addresses.
`ifndef IRQ_CTRL_DEFS_VH
`define IRQ_CTRL_DEFS_VH
`define ADDR_BASE_EN 8'ha8
`define ADDR_BASE_LVL 8'hb8
`define ADDR_EXT_EN1 8'he6
`define ADDR_EXT_EN2 8'he7
`define ADDR_EXT_LVL1 8'hf6
`define ADDR_EXT_LVL2 8'hf7
`define RST_BASE_EN 8'h00
`define RST_BASE_LVL 8'h80
`define RST_EXT 8'h00
`define GATE_BIT 7
`define EXT2_MASK 8'h03
`define NUM_SRC 17
`define SRC_W 5
`define VEC_BASE 16'h0003
`define VEC_STEP_SHIFT 3
`define SRC_EXT0 5'h00
`define SRC_TMR0 5'h01
`define SRC_EXT1 5'h02
`define SRC_TMR1 5'h03
`define SRC_TMR2 5'h05
`define SRC_RTC 5'h08
`define SRC_TMR3 5'h0e
`define DETECT_CYCLES 4'h1
`define CALL_CYCLES 4'h5
`endif

// File: rtl/irq_arbiter.v
// Fixed-order arbiter picking the lowest numbered active request.
// Assumes the requests are already masked and level-filtered.
`timescale 1ns/1ps
`include "irq_ctrl_defs.vh"
module irq_arbiter #(
   parameter N = `NUM_SRC
) (
   input wire [N-1:0] req_i,
   output reg found_o,
   output reg [`SRC_W-1:0] idx_o
);
   integer k;
   always @* begin
      found_o = 1'b0;
      idx_o = {`SRC_W{1'b0}};
      for (k = N - 1; k >= 0; k = k - 1) begin
         if (req_i[k]) begin
            found_o = 1'b1;
            idx_o = k[`SRC_W-1:0];
         end
      end
   end
endmodule // irq_arbiter

// File: rtl/irq_controller.v
// Two-level prioritized interrupt controller with special register access.
// Assumes the core pulses done strobes and honours the vector handshake.
`timescale 1ns/1ps
`include "irq_ctrl_defs.vh"
// Contract
// - Requests are sampled and arbitrated anew each clock cycle.
// - Best case: one detect cycle, one instruction, five-cycle vector call.
// - After a return, one more instruction runs before a pending call.
// - Worst case nineteen cycles: detect, return, divide, vector call.
// - Equal or lower level waits for return plus one instruction.
// - Vectors fixed: reset 0x0000, source 0 at 0x0003, step eight.
// - Same level ties go to lowest order number; reset highest.
// - Hardware clears only ext0, timer0, ext1, timer1 flags on vectoring.
// - Multi-flag sources request when any of their flags is set.
// - Global gate bit 7 overrides all masks; zero blocks everything.
// - Base enable at 0xA8 holds seven source enables, bits 6..0.
// - Base level at 0xB8 holds level bits, one means high.
// - Base level bit 7 reads one and ignores writes.
// - Extended enable one at 0xE6 holds eight further source enables.
// - Extended level one at 0xF6 holds matching levels, reset zero.
// - Extended enable two at 0xE7: port match bit 1, dropout bit 0.
// - Extended level two at 0xF7: same bits, upper six read zero.
// - Clock source requests on alarm or oscillator fault when enabled.
// - Pending flags set regardless of enables; masks only gate requests.
// - Requests held while gated off are serviced when gate returns.
// - A flag still set after return requests again at once.
// - High preempts low service; nothing preempts high service.
module irq_controller #(
   parameter NSRC = `NUM_SRC
) (
   input wire ref_clk_i,
   input wire sys_rst_i,
   input wire [7:0] sfr_addr_i,
   input wire [7:0] sfr_wdata_i,
   input wire sfr_wr_i,
   output reg [7:0] sfr_rdata_o,
   input wire ext_in0_pending_i,
   input wire timer0_overflow_flag_i,
   input wire ext_in1_pending_i,
   input wire timer1_overflow_flag_i,
   input wire [1:0] uart_flags_i,
   input wire timer2_upper_overflow_i,
   input wire timer2_lower_overflow_i,
   input wire [3:0] spi_flags_i,
   input wire twowire_flag_i,
   input wire rtc_alarm_flag_i,
   input wire rtc_osc_fault_flag_i,
   input wire conv_window_flag_i,
   input wire conv_done_flag_i,
   input wire [6:0] counter_array_flags_i,
   input wire [1:0] cmp0_flags_i,
   input wire [1:0] cmp1_flags_i,
   input wire timer3_upper_overflow_i,
   input wire timer3_lower_overflow_i,
   input wire regulator_drop_i,
   input wire port_match_i,
   input wire insn_done_i,
   input wire return_done_i,
   input wire call_done_i,
   output wire irq_req_o,
   output reg [15:0] vector_addr_o,
   output reg vector_take_o,
   output reg [3:0] auto_clear_o,
   output reg [1:0] in_service_o
);
   reg [7:0] base_irq_enable_mask_q;
   reg [6:0] base_irq_level_select_q;
   reg [7:0] ext_irq_enable_first_q;
   reg [1:0] ext_irq_enable_second_q;
   reg [7:0] ext_irq_level_first_q;
   reg [1:0] ext_irq_level_second_q;
   localparam [1:0] ST_IDLE = 2'h0;
   localparam [1:0] ST_ARM = 2'h1;
   localparam [1:0] ST_HOLD = 2'h2;
   reg [1:0] state_q;
   reg [1:0] state_d;
   wire [NSRC-1:0] raw_req;
   wire [NSRC-1:0] en_vec;
   wire [NSRC-1:0] lvl_vec;
   wire [NSRC-1:0] live;
   wire [NSRC-1:0] hi_req;
   wire [NSRC-1:0] lo_req;
   wire hi_found;
   wire lo_found;
   wire [`SRC_W-1:0] hi_idx;
   wire [`SRC_W-1:0] lo_idx;
   wire global_irq_gate;
   wire hi_ok;
   wire lo_ok;
   wire win_found;
   wire [`SRC_W-1:0] win_idx;
   wire win_lvl;

   // Vector address of a source number, eight bytes apart.
   function [15:0] vec_of;
      input [`SRC_W-1:0] idx;
      begin
         vec_of = `VEC_BASE + ({11'h000, idx} << `VEC_STEP_SHIFT);
      end
   endfunction

   // Multi-flag sources are an OR of their flags.
   assign raw_req = {port_match_i, regulator_drop_i,
      timer3_upper_overflow_i | timer3_lower_overflow_i,
      |cmp1_flags_i, |cmp0_flags_i, |counter_array_flags_i,
      conv_done_flag_i, conv_window_flag_i,
      rtc_alarm_flag_i | rtc_osc_fault_flag_i,
      twowire_flag_i, |spi_flags_i,
      timer2_upper_overflow_i | timer2_lower_overflow_i,
      |uart_flags_i, timer1_overflow_flag_i, ext_in1_pending_i,
      timer0_overflow_flag_i, ext_in0_pending_i};

   assign en_vec = {ext_irq_enable_second_q, ext_irq_enable_first_q,
      base_irq_enable_mask_q[6:0]};
   assign lvl_vec = {ext_irq_level_second_q, ext_irq_level_first_q,
      base_irq_level_select_q};
   assign global_irq_gate = base_irq_enable_mask_q[`GATE_BIT];

   // Flags are never stored here, so they stay pending while masked.
   assign live = raw_req & en_vec & {NSRC{global_irq_gate}};
   assign hi_req = live & lvl_vec;
   assign lo_req = live & ~lvl_vec;

   irq_arbiter #(.N(NSRC)) u_hi_arb (
      .req_i(hi_req),
      .found_o(hi_found),
      .idx_o(hi_idx)
   );
   irq_arbiter #(.N(NSRC)) u_lo_arb (
      .req_i(lo_req),
      .found_o(lo_found),
      .idx_o(lo_idx)
   );

   // High may enter unless high is in service; low needs both idle.
   assign hi_ok = hi_found & ~in_service_o[1];
   assign lo_ok = lo_found & ~in_service_o[1] & ~in_service_o[0];
   assign win_found = hi_ok | lo_ok;
   assign win_idx = hi_ok ? hi_idx : lo_idx;
   assign win_lvl = hi_ok;
   assign irq_req_o = (state_q != ST_IDLE);

   // Arm waits one instruction boundary after detection; the vector call
   // itself is timed by the core, so the five cycles end on call_done.
   // An instruction end that coincides with a return is the return itself,
   // so the first call after a return follows one whole instruction.
   always @* begin
      state_d = state_q;
      case (state_q)
         ST_IDLE: begin
            if (win_found) begin
               state_d = ST_ARM;
            end
         end
         ST_ARM: begin
            if (!win_found) begin
               state_d = ST_IDLE;
            end else if (insn_done_i && !return_done_i) begin
               state_d = ST_HOLD;
            end
         end
         ST_HOLD: begin
            if (call_done_i) begin
               state_d = ST_IDLE;
            end
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   always @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         state_q <= ST_IDLE;
         vector_addr_o <= 16'h0000;
         vector_take_o <= 1'b0;
         auto_clear_o <= 4'h0;
         in_service_o <= 2'h0;
      end else begin
         state_q <= state_d;
         vector_take_o <= 1'b0;
         auto_clear_o <= 4'h0;
         if (state_q == ST_ARM && state_d == ST_HOLD) begin
            vector_addr_o <= vec_of(win_idx);
            vector_take_o <= 1'b1;
            if (win_idx == `SRC_EXT0) begin
               auto_clear_o[0] <= 1'b1;
            end
            if (win_idx == `SRC_TMR0) begin
               auto_clear_o[1] <= 1'b1;
            end
            if (win_idx == `SRC_EXT1) begin
               auto_clear_o[2] <= 1'b1;
            end
            if (win_idx == `SRC_TMR1) begin
               auto_clear_o[3] <= 1'b1;
            end
         end
         // Return clears the highest active level; a new entry wins.
         if (state_q == ST_ARM && state_d == ST_HOLD) begin
            if (win_lvl) begin
               in_service_o[1] <= 1'b1;
            end else begin
               in_service_o[0] <= 1'b1;
            end
         end else if (return_done_i) begin
            // Clearing here lets a flag still set re-arm at once.
            if (in_service_o[1]) begin
               in_service_o[1] <= 1'b0;
            end else begin
               in_service_o[0] <= 1'b0;
            end
         end
      end
   end

   always @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         base_irq_enable_mask_q <= `RST_BASE_EN;
         base_irq_level_select_q <= 7'h00;
         ext_irq_enable_first_q <= `RST_EXT;
         ext_irq_enable_second_q <= 2'h0;
         ext_irq_level_first_q <= `RST_EXT;
         ext_irq_level_second_q <= 2'h0;
      end else if (sfr_wr_i) begin
         case (sfr_addr_i)
            `ADDR_BASE_EN: base_irq_enable_mask_q <= sfr_wdata_i;
            `ADDR_BASE_LVL: begin
               base_irq_level_select_q <= sfr_wdata_i[6:0];
            end
            `ADDR_EXT_EN1: ext_irq_enable_first_q <= sfr_wdata_i;
            `ADDR_EXT_EN2: begin
               ext_irq_enable_second_q <= sfr_wdata_i[1:0];
            end
            `ADDR_EXT_LVL1: ext_irq_level_first_q <= sfr_wdata_i;
            `ADDR_EXT_LVL2: begin
               ext_irq_level_second_q <= sfr_wdata_i[1:0];
            end
            default: begin
            end
         endcase
      end
   end

   always @* begin
      case (sfr_addr_i)
         `ADDR_BASE_EN: sfr_rdata_o = base_irq_enable_mask_q;
         `ADDR_BASE_LVL: begin
            // Bit 7 is not stored; it is forced to one on every read.
            sfr_rdata_o = `RST_BASE_LVL | {1'b0, base_irq_level_select_q};
         end
         `ADDR_EXT_EN1: sfr_rdata_o = ext_irq_enable_first_q;
         `ADDR_EXT_EN2:
            sfr_rdata_o = {6'h00, ext_irq_enable_second_q} & `EXT2_MASK;
         `ADDR_EXT_LVL1: sfr_rdata_o = ext_irq_level_first_q;
         `ADDR_EXT_LVL2:
            sfr_rdata_o = {6'h00, ext_irq_level_second_q} & `EXT2_MASK;
         default: sfr_rdata_o = 8'h00;
      endcase
   end
endmodule // irq_controller

// File: tb/irq_ctrl_assertions.sv
// Port checker for the interrupt controller.
// Assumes it is bound to irq_controller and sees only its ports.
`timescale 1ns/1ps
`include "irq_ctrl_defs.vh"
module irq_ctrl_checker (
   input wire ref_clk_i,
   input wire sys_rst_i,
   input wire [7:0] sfr_addr_i,
   input wire [7:0] sfr_rdata_o,
   input wire insn_done_i,
   input wire return_done_i,
   input wire irq_req_o,
   input wire [15:0] vector_addr_o,
   input wire vector_take_o,
   input wire [3:0] auto_clear_o,
   input wire [1:0] in_service_o
);
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (sys_rst_i);
   a_vec_on_grid: assert property (vector_take_o |->
      vector_addr_o[2:0] == 3'h3 && vector_addr_o <= 16'h0083)
      else $error("vector off grid");
   a_take_has_cause: assert property (vector_take_o |->
      $past(irq_req_o) && $past(insn_done_i) && !$past(return_done_i))
      else $error("take uncaused");
   a_clear_map: assert property (vector_take_o |-> auto_clear_o ==
      (vector_addr_o < 16'h0020 ? 4'h1 << vector_addr_o[4:3] : 4'h0))
      else $error("auto clear wrong");
   a_clear_with_take: assert property (auto_clear_o != 4'h0 |->
      vector_take_o) else $error("stray auto clear");
   a_take_marks_level: assert property (vector_take_o |->
      in_service_o != 2'h0) else $error("no level in service");
   a_high_not_preempted: assert property ($past(in_service_o[1]) |->
      !vector_take_o) else $error("high routine preempted");
   a_ret_no_take: assert property (return_done_i |=> !vector_take_o)
      else $error("take right after return");
   a_ret_one_insn: assert property (return_done_i ##1 !insn_done_i |=>
      !vector_take_o) else $error("take before next instruction");
   a_lvl_top_bit: assert property (sfr_addr_i == `ADDR_BASE_LVL |->
      sfr_rdata_o[7]) else $error("level top bit not one");
   a_ext2_upper: assert property (sfr_addr_i == `ADDR_EXT_EN2 ||
      sfr_addr_i == `ADDR_EXT_LVL2 |-> sfr_rdata_o[7:2] == 6'h00)
      else $error("upper bits not zero");
endmodule // irq_ctrl_checker
bind irq_controller irq_ctrl_checker i_irq_ctrl_checker (.ref_clk_i,
   .sys_rst_i, .sfr_addr_i, .sfr_rdata_o, .insn_done_i, .return_done_i,
   .irq_req_o, .vector_addr_o, .vector_take_o, .auto_clear_o, .in_service_o);

// File: tb/core_model.sv
// Behavioural core: runs instructions, vector calls, routines, returns.
// Assumes the controller pulses vector_take for one cycle per grant.
`timescale 1ns/1ps
module core_model (
   input wire ref_clk_i,
   input wire sys_rst_i,
   input wire vector_take_i,
   input wire [3:0] insn_len_i,
   input wire [7:0] isr_len_i,
   output reg insn_done_o,
   output reg return_done_o,
   output reg call_done_o
);
   reg [1:0] mode_q;
   reg [7:0] cnt_q;
   reg [3:0] depth_q;
   // Nested routines resume briefly so the outer one can still return.
   always @(posedge ref_clk_i) begin
      insn_done_o <= 1'b0;
      return_done_o <= 1'b0;
      call_done_o <= 1'b0;
      if (sys_rst_i) begin
         mode_q <= 2'h0;
         cnt_q <= 8'h00;
         depth_q <= 4'h0;
      end else if (vector_take_i) begin
         mode_q <= 2'h1;
         cnt_q <= 8'h04;
         depth_q <= depth_q + 4'h1;
      end else if (mode_q == 2'h2) begin
         insn_done_o <= cnt_q != 8'h00;
         cnt_q <= cnt_q - 8'h01;
         if (cnt_q == 8'h00) begin
            mode_q <= 2'h3;
            cnt_q <= 8'h04;
         end
      end else if (cnt_q != 8'h00) begin
         cnt_q <= cnt_q - 8'h01;
      end else if (mode_q == 2'h0) begin
         insn_done_o <= 1'b1;
         cnt_q <= {4'h0, insn_len_i} - 8'h01;
      end else if (mode_q == 2'h1) begin
         call_done_o <= 1'b1;
         mode_q <= 2'h2;
         cnt_q <= isr_len_i;
      end else begin
         return_done_o <= 1'b1;
         depth_q <= depth_q - 4'h1;
         mode_q <= depth_q > 4'h1 ? 2'h2 : 2'h0;
         cnt_q <= depth_q > 4'h1 ? 8'h02 : {4'h0, insn_len_i} - 8'h01;
      end
   end
endmodule // core_model

// File: tb/tb_irq_controller.sv
// Self-checking bench for the interrupt controller with a core model.
// Assumes the register bus and core strobes behave as in the hand-over.
`timescale 1ns/1ps
module tb_irq_controller;
   logic ref_clk_i, sys_rst_i, sfr_wr_i, alt_q;
   logic [7:0] sfr_addr_i, sfr_wdata_i, isr_len_q;
   logic [3:0] insn_len_q, auto_clear_o;
   logic [16:0] src_q;
   wire [7:0] sfr_rdata_o;
   wire [15:0] vector_addr_o;
   wire [1:0] in_service_o;
   wire insn_done_i, return_done_i, call_done_i, irq_req_o, vector_take_o;
   wire [6:0] ma = alt_q ? 7'h55 : 7'h2a;
   logic [7:0] ad [7] = '{8'ha8, 8'hb8, 8'he6, 8'he7, 8'hf6, 8'hf7, 8'h00};
   int fail_count, total_checks, n, k, a, i;
   irq_controller i_irq_controller (.ref_clk_i, .sys_rst_i, .sfr_addr_i,
      .sfr_wdata_i, .sfr_wr_i, .sfr_rdata_o, .ext_in0_pending_i(src_q[0]),
      .timer0_overflow_flag_i(src_q[1]), .ext_in1_pending_i(src_q[2]),
      .timer1_overflow_flag_i(src_q[3]),
      .uart_flags_i({2{src_q[4]}} & ma[1:0]),
      .timer2_upper_overflow_i(src_q[5] & ma[0]),
      .timer2_lower_overflow_i(src_q[5] & ma[1]),
      .spi_flags_i({4{src_q[6]}} & ma[3:0]), .twowire_flag_i(src_q[7]),
      .rtc_alarm_flag_i(src_q[8] & ma[0]),
      .rtc_osc_fault_flag_i(src_q[8] & ma[1]), .conv_window_flag_i(src_q[9]),
      .conv_done_flag_i(src_q[10]), .counter_array_flags_i({7{src_q[11]}} & ma),
      .cmp0_flags_i({2{src_q[12]}} & ma[1:0]),
      .cmp1_flags_i({2{src_q[13]}} & ma[1:0]),
      .timer3_upper_overflow_i(src_q[14] & ma[0]),
      .timer3_lower_overflow_i(src_q[14] & ma[1]),
      .regulator_drop_i(src_q[15]), .port_match_i(src_q[16]), .insn_done_i,
      .return_done_i, .call_done_i, .irq_req_o, .vector_addr_o,
      .vector_take_o, .auto_clear_o, .in_service_o);
   core_model i_core_model (.ref_clk_i, .sys_rst_i,
      .vector_take_i(vector_take_o), .insn_len_i(insn_len_q),
      .isr_len_i(isr_len_q), .insn_done_o(insn_done_i),
      .return_done_o(return_done_i), .call_done_o(call_done_i));
   task chk(input string nm, input logic [15:0] s, input logic [15:0] e);
      total_checks++;
      if (s !== e) begin
         $display("ERROR %s expected %h seen %h", nm, e, s);
         fail_count++;
      end
   endtask
   task wr(input logic [7:0] ad_v, input logic [7:0] d);
      @(posedge ref_clk_i);
      sfr_addr_i <= ad_v;
      sfr_wdata_i <= d;
      sfr_wr_i <= 1'b1;
      @(posedge ref_clk_i);
      sfr_wr_i <= 1'b0;
   endtask
   task rd(input logic [7:0] ad_v, input logic [7:0] d);
      logic [7:0] e;
      @(posedge ref_clk_i);
      sfr_addr_i <= ad_v;
      @(posedge ref_clk_i);
      #1;
      // Unmapped reads 0; the level top bit is fixed; extended second regs
      // keep two bits only.
      e = ad_v[3:0] == 4'h7 ? d & 8'h03 : d;
      e = ad_v == 8'hb8 ? d | 8'h80 : e;
      e = ad_v == 8'h00 ? 8'h00 : e;
      chk("rdata", {8'h00, sfr_rdata_o}, {8'h00, e});
   endtask
   task wait_on(input bit ret);
      n = 0;
      do begin
         @(posedge ref_clk_i);
         #1;
         n++;
      end while ((ret ? return_done_i : vector_take_o) !== 1'b1 && n < 400);
      chk("wait_limit", 16'(n >= 400), 16'h0);
   endtask
   task take(input logic [15:0] v, input logic [1:0] s);
      wait_on(0);
      chk("vector", vector_addr_o, v);
      chk("in_service", {14'h0, in_service_o}, {14'h0, s});
   endtask
   task give_verdict;
      if (fail_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      ref_clk_i = 1'b0;
      forever #12.5 ref_clk_i = ~ref_clk_i;
   end
   initial begin
      #(25 * 40000);
      fail_count++;
      give_verdict;
   end
   initial begin
      {fail_count, total_checks, sfr_addr_i, sfr_wdata_i, sfr_wr_i} = 0;
      {src_q, alt_q, sys_rst_i, insn_len_q, isr_len_q} = {18'h0, 1'b1, 4'h1,
         8'd30};
      repeat (3) @(posedge ref_clk_i);
      sys_rst_i <= 1'b0;
      for (k = 0; k < 7; k++) rd(ad[k], 8'h00);
      for (i = 0; i < 2; i++) begin
         for (k = 0; k < 7; k++) wr(ad[k], i ? 8'h00 : 8'hff);
         for (k = 0; k < 7; k++) rd(ad[k], i ? 8'h00 : 8'hff);
      end
      wr(8'ha8, 8'hff);
      wr(8'he6, 8'hff);
      wr(8'he7, 8'hff);
      for (a = 0; a < 2; a++) for (i = 0; i < 17; i++) begin
         @(posedge ref_clk_i);
         alt_q <= a[0];
         src_q <= 17'h1 << i;
         take(16'(3 + 8 * i), 2'h1);
         chk("latency", 16'(n), 16'd2);
         chk("auto_clear", {12'h0, auto_clear_o},
            i < 4 ? 16'h1 << i : 16'h0);
         @(posedge ref_clk_i);
         src_q <= 17'h0;
         wait_on(1);
         repeat (3) @(posedge ref_clk_i);
      end
      wr(8'hf7, 8'h02);
      src_q <= 17'h1ffff;
      take(16'h0083, 2'h2);
      wait_on(1);
      take(16'h0083, 2'h2);
      src_q <= 17'h0ffff;
      wait_on(1);
      take(16'h0003, 2'h1);
      src_q <= 17'h1fffe;
      take(16'h0083, 2'h3);
      src_q <= 17'h0;
      wait_on(1);
      wait_on(1);
      wr(8'hf7, 8'h00);
      insn_len_q <= 4'h8;
      src_q <= 17'h3;
      take(16'h0003, 2'h1);
      src_q <= 17'h2;
      wait_on(1);
      take(16'h000b, 2'h1);
      chk("ret_latency", 16'(n), 16'd9);
      src_q <= 17'h0;
      insn_len_q <= 4'h1;
      wait_on(1);
      wr(8'ha8, 8'h7f);
      src_q <= 17'h4;
      repeat (10) @(posedge ref_clk_i);
      chk("gated_req", {15'h0, irq_req_o}, 16'h0);
      wr(8'ha8, 8'hff);
      take(16'h0013, 2'h1);
      give_verdict;
   end
endmodule // tb_irq_controller
